//--- bcdcal_dev.sv
// Device end: BCD minute, hour, weekday, date and month counters.
// Assumes a one-second tick, seconds carry and year wrap from logic
// on clk_in; oscillator pulse and supply flags arrive from pins.
//
// Functional notes
// RULE_01 - Four missed oscillator pulses latch failure flag
// RULE_02 - Failure flag set at reset, host clears
// RULE_03 - Minute tens digit legal zero to five
// RULE_04 - Illegal digits advance until rollover
// RULE_05 - Minute units digit legal zero to nine
// RULE_06 - Fields refresh within one second after backup
// RULE_07 - Century bit kept only when tracking enabled
// RULE_08 - Century bit toggles on year wrap
// RULE_09 - Hours 24-hour form, tens zero to two
// RULE_10 - Hour units digit zero to nine
// RULE_11 - Weekday counts one to seven, wraps
// RULE_12 - Weekday zero still advances until wrap
// RULE_13 - Host writes zero to unused bits
// RULE_14 - Date digits form legal day of month
// RULE_15 - Month digits form month one to twelve
// RULE_16 - Hour register bit layout
// RULE_17 - Weekday register bit layout
// RULE_18 - Date register bit layout
// RULE_19 - Month register bit layout
// RULE_20 - Minute register at one, flag bit 7
// RULE_21 - Refuse access while on backup supply
// RULE_22 - Counters carry into next on wrap
`timescale 1ns/1ps
`default_nettype none
`include "bcdcal_cfg.svh"
module bcdcal_dev #(
    parameter int MISS_LIMIT = `BCDCAL_MISS_LIMIT,
    parameter int OSC_GAP_CYC = `BCDCAL_OSC_GAP_CYC,
    parameter int REFRESH_CYC = `BCDCAL_REFRESH_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sec_tick_in,
    input wire logic sec_carry_in,
    input wire logic year_wrap_in,
    input wire logic leap_year_in,
    input wire logic osc_pulse_in,
    input wire logic main_power_ok_in,
    bcdcal_if.dev bus,
    output logic osc_fail_flag_out,
    output logic fields_valid_out
);
    import bcdcal_pkg::*;

    bcdcal_byte_t minute_r, hour_r, wday_r, mday_r, month_r, rdata_r;
    logic ack_r, refused_r, valid_r;
    logic [2:0] osc_sync_r, pwr_sync_r;
    logic [15:0] gap_cnt_r;
    logic [3:0] miss_cnt_r;
    logic [31:0] refresh_cnt_r;
    logic osc_prev_r;
    logic miss_now;
    logic [7:0] min_next, hr_next, mday_next, mon_next, mdays;

    // One BCD step: units wrap at 9, tens bump; illegal units just count
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_days(input logic [4:0] m,
                                               input logic leap);
        case (m)
            5'h02: month_days = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_days = 8'h30;
            default: month_days = 8'h31;
        endcase
    endfunction

    // Three-stage sync; change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_sync_r <= 3'h0;
            pwr_sync_r <= 3'h0;
        end else begin
            osc_sync_r <= {osc_sync_r[1:0], osc_pulse_in};
            pwr_sync_r <= {pwr_sync_r[1:0], main_power_ok_in};
        end
    end

    wire osc_stable = (osc_sync_r[1] == osc_sync_r[2]);
    wire pwr_ok = pwr_sync_r[2] & pwr_sync_r[1];

    // Missed pulse = no oscillator edge within one expected period
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_prev_r <= 1'b0;
            gap_cnt_r <= 16'h0000;
            miss_cnt_r <= 4'h0;
        end else if (osc_stable) begin
            osc_prev_r <= osc_sync_r[2];
            if (osc_sync_r[2] & ~osc_prev_r) begin
                gap_cnt_r <= 16'h0000;
                miss_cnt_r <= 4'h0;
            end else if (gap_cnt_r == 16'(OSC_GAP_CYC - 1)) begin
                gap_cnt_r <= 16'h0000;
                if (miss_cnt_r != 4'hf)
                    miss_cnt_r <= miss_cnt_r + 4'h1;
            end else begin
                gap_cnt_r <= gap_cnt_r + 16'h0001;
            end
        end
    end

    assign miss_now = (miss_cnt_r >= 4'(MISS_LIMIT));

    // Refresh window after return to main supply
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refresh_cnt_r <= 32'h0;
            valid_r <= 1'b0;
        end else if (!pwr_ok) begin
            refresh_cnt_r <= 32'h0;
            valid_r <= 1'b0;
        end else if (refresh_cnt_r == 32'(REFRESH_CYC - 1)) begin
            valid_r <= 1'b1; // [RULE_06]
        end else begin
            refresh_cnt_r <= refresh_cnt_r + 32'h1;
        end
    end

    wire wr_hit = bus.req & bus.wr & pwr_ok; // [RULE_21]
    wire min_wrap = (minute_r[6:0] == 7'h59);
    wire hr_wrap = (hour_r[5:0] == 6'h23);
    wire day_roll = sec_tick_in & sec_carry_in & min_wrap & hr_wrap;
    // A call result cannot be sliced, so each step gets its own net
    assign min_next = bcd_inc({1'b0, minute_r[6:0]});
    assign hr_next = bcd_inc({2'b00, hour_r[5:0]});
    assign mday_next = bcd_inc({2'b00, mday_r[5:0]});
    assign mon_next = bcd_inc({3'h0, month_r[4:0]});
    assign mdays = month_days(month_r[4:0], leap_year_in);
    wire mday_end = (mday_r[5:0] == mdays[5:0]);

    // Minute register and oscillator-failure flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            minute_r <= `BCDCAL_MINUTE_RST; // [RULE_02] [RULE_20]
        end else begin
            if (wr_hit && bus.addr == `BCDCAL_OFF_MINUTE)
                minute_r <= bus.wdata;
            else if (sec_tick_in && sec_carry_in)
                // Tens may start illegal; any step that overflows wraps
                minute_r[6:0] <= min_wrap ? 7'h00
                    : min_next[6:0];
                    // [RULE_03] [RULE_04] [RULE_05] [RULE_22]
            if (miss_now)
                minute_r[`BCDCAL_OSC_FAIL_BIT] <= 1'b1; // [RULE_01]
        end
    end

    // Hour and century
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hour_r <= `BCDCAL_HOUR_RST;
        end else if (wr_hit && bus.addr == `BCDCAL_OFF_HOUR) begin
            hour_r <= bus.wdata; // [RULE_16]
        end else begin
            if (sec_tick_in && sec_carry_in && min_wrap)
                hour_r[5:0] <= hr_wrap ? 6'h00
                    : hr_next[5:0];
                    // [RULE_09] [RULE_10] [RULE_04] [RULE_22]
            if (year_wrap_in && hour_r[`BCDCAL_HUNDRED_YEAR_TRACK_ENABLE_BIT])
                hour_r[`BCDCAL_HUNDRED_YEAR_TOGGLE_BIT] <= ~hour_r[`BCDCAL_HUNDRED_YEAR_TOGGLE_BIT];
                // [RULE_07] [RULE_08]
        end
    end

    // Weekday, date, month
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wday_r <= `BCDCAL_WEEKDAY_RST;
            mday_r <= `BCDCAL_MDAY_RST;
            month_r <= `BCDCAL_MONTH_RST;
        end else begin
            if (wr_hit && bus.addr == `BCDCAL_OFF_WEEKDAY)
                wday_r <= {5'h00, bus.wdata[2:0]}; // [RULE_17] [RULE_13]
            else if (day_roll)
                wday_r[2:0] <= (wday_r[2:0] == 3'h7) ? 3'h1
                    : wday_r[2:0] + 3'h1; // [RULE_11] [RULE_12]
            if (wr_hit && bus.addr == `BCDCAL_OFF_MDAY)
                mday_r <= {2'b00, bus.wdata[5:0]}; // [RULE_18]
            else if (day_roll)
                mday_r[5:0] <= mday_end ? 6'h01
                    : mday_next[5:0]; // [RULE_14]
            if (wr_hit && bus.addr == `BCDCAL_OFF_MONTH)
                month_r <= {3'h0, bus.wdata[4:0]}; // [RULE_19]
            else if (day_roll && mday_end)
                month_r[4:0] <= (month_r[4:0] == 5'h12) ? 5'h01
                    : mon_next[4:0];
                    // [RULE_15] [RULE_22]
        end
    end

    // Read path and answer; one-cycle ack, refusal on backup supply
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
            refused_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= bus.req & pwr_ok;
            refused_r <= bus.req & ~pwr_ok; // [RULE_21]
            if (bus.req && !bus.wr && pwr_ok) begin
                if (bus.addr == `BCDCAL_OFF_MINUTE)
                    rdata_r <= minute_r;
                else if (bus.addr == `BCDCAL_OFF_HOUR)
                    rdata_r <= hour_r;
                else if (bus.addr == `BCDCAL_OFF_WEEKDAY)
                    rdata_r <= wday_r;
                else if (bus.addr == `BCDCAL_OFF_MDAY)
                    rdata_r <= mday_r;
                else if (bus.addr == `BCDCAL_OFF_MONTH)
                    rdata_r <= month_r;
                else
                    rdata_r <= 8'h00;
            end
        end
    end

    assign bus.ack = ack_r;
    assign bus.refused = refused_r;
    assign bus.rdata = rdata_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_fail_flag_out <= 1'b1;
            fields_valid_out <= 1'b0;
        end else begin
            osc_fail_flag_out <= minute_r[`BCDCAL_OSC_FAIL_BIT];
            fields_valid_out <= valid_r;
        end
    end
endmodule
`default_nettype wire

//--- bcdcal_cfg.svh
// Constants for the minute-to-month timekeeping group.
// Included by both ends; definitions only.
`ifndef BCDCAL_CFG_SVH
`define BCDCAL_CFG_SVH

`define BCDCAL_OFF_MINUTE 4'h1
`define BCDCAL_OFF_HOUR 4'h2
`define BCDCAL_OFF_WEEKDAY 4'h3
`define BCDCAL_OFF_MDAY 4'h4
`define BCDCAL_OFF_MONTH 4'h5
`define BCDCAL_OSC_FAIL_BIT 7
`define BCDCAL_HUNDRED_YEAR_TRACK_ENABLE_BIT 7
`define BCDCAL_HUNDRED_YEAR_TOGGLE_BIT 6
`define BCDCAL_MINUTE_RST 8'h80
`define BCDCAL_HOUR_RST 8'h00
`define BCDCAL_WEEKDAY_RST 8'h01
`define BCDCAL_MDAY_RST 8'h01
`define BCDCAL_MONTH_RST 8'h01
`define BCDCAL_MISS_LIMIT 4
`define BCDCAL_OSC_GAP_CYC 1300
`define BCDCAL_CLK_HZ 40000000
`define BCDCAL_REFRESH_S 1
`define BCDCAL_REFRESH_CYC (`BCDCAL_CLK_HZ * `BCDCAL_REFRESH_S)

`endif

//--- bcdcal_pkg.sv
// Types shared by both ends of the timekeeping group.
// Assumes bcdcal_cfg.svh is on the include path.
package bcdcal_pkg;
    typedef logic [7:0] bcdcal_byte_t;
    typedef logic [3:0] bcdcal_addr_t;
endpackage

//--- bcdcal_if.sv
// Register access path between host logic and the timekeeping group.
// Assumes one shared clock; testbench joins the two ends.
`timescale 1ns/1ps
`default_nettype none
interface bcdcal_if;
    import bcdcal_pkg::*;
    logic req;
    logic wr;
    bcdcal_addr_t addr;
    bcdcal_byte_t wdata;
    logic ack;
    logic refused;
    bcdcal_byte_t rdata;
    modport dev (input req, wr, addr, wdata, output ack, refused, rdata);
    modport host (output req, wr, addr, wdata, input ack, refused, rdata);
endinterface
`default_nettype wire

//--- bcdcal_host.sv
// Host end: turns one user command into one register access.
// Assumes the device end answers on the shared interface.
`timescale 1ns/1ps
`default_nettype none
`include "bcdcal_cfg.svh"
module bcdcal_host (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire bcdcal_pkg::bcdcal_addr_t cmd_addr_in,
    input wire bcdcal_pkg::bcdcal_byte_t cmd_data_in,
    bcdcal_if.host bus,
    output logic cmd_ready_out,
    output logic done_out,
    output logic refused_out,
    output bcdcal_pkg::bcdcal_byte_t rdata_out
);
    import bcdcal_pkg::*;

    typedef enum {BCDCAL_IDLE, BCDCAL_WAIT} bcdcal_state_t;
    bcdcal_state_t state_r;
    logic req_r, wr_r;
    bcdcal_addr_t addr_r;
    bcdcal_byte_t wdata_r;

    // Unused bits forced to zero on weekday, date, month writes
    function automatic bcdcal_byte_t clean(input bcdcal_addr_t a,
                                           input bcdcal_byte_t d);
        if (a == `BCDCAL_OFF_WEEKDAY)
            clean = {5'h00, d[2:0]};
        else if (a == `BCDCAL_OFF_MDAY)
            clean = {2'b00, d[5:0]};
        else if (a == `BCDCAL_OFF_MONTH)
            clean = {3'h0, d[4:0]};
        else
            clean = d;
    endfunction

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= BCDCAL_IDLE;
            req_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 4'h0;
            wdata_r <= 8'h00;
            cmd_ready_out <= 1'b0;
            done_out <= 1'b0;
            refused_out <= 1'b0;
            rdata_out <= 8'h00;
        end else begin
            done_out <= 1'b0;
            refused_out <= 1'b0;
            req_r <= 1'b0;
            case (state_r)
                BCDCAL_IDLE: begin
                    cmd_ready_out <= 1'b1;
                    if (cmd_valid_in && cmd_ready_out) begin
                        req_r <= 1'b1;
                        wr_r <= cmd_write_in;
                        addr_r <= cmd_addr_in;
                        wdata_r <= clean(cmd_addr_in, cmd_data_in); // [RULE_13]
                        cmd_ready_out <= 1'b0;
                        state_r <= BCDCAL_WAIT;
                    end
                end
                BCDCAL_WAIT: begin
                    if (bus.ack || bus.refused) begin
                        done_out <= bus.ack;
                        refused_out <= bus.refused; // [RULE_21]
                        if (bus.ack && !wr_r)
                            rdata_out <= bus.rdata;
                        cmd_ready_out <= 1'b1;
                        state_r <= BCDCAL_IDLE;
                    end
                end
                default: state_r <= BCDCAL_IDLE;
            endcase
        end
    end

    assign bus.req = req_r;
    assign bus.wr = wr_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
endmodule
`default_nettype wire

//--- bcdcal_asserts.sv
// Checker for the register path between the host and device ends.
// Sees interface signals only; instantiated beside the interface.
`timescale 1ns/1ps
`default_nettype none
module bcdcal_asserts
import bcdcal_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req,
    input wire logic wr,
    input wire bcdcal_addr_t addr,
    input wire bcdcal_byte_t wdata,
    input wire logic ack,
    input wire logic refused,
    input wire bcdcal_byte_t rdata
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_answer; req |=> (ack ^ refused); endproperty
    a_answer: assert property (p_answer)
        else $error("request without a single answer");
    property p_cause; (ack || refused) |-> $past(req); endproperty
    a_cause: assert property (p_cause)
        else $error("answer without request");
    property p_req_once; req |=> !req; endproperty
    a_req_once: assert property (p_req_once)
        else $error("request held too long");
    property p_keep; refused |-> $stable(rdata); endproperty
    a_keep: assert property (p_keep)
        else $error("refused access changed read data");
    property p_rd_wday;
        ack && !$past(wr) && $past(addr) == 4'h3 |-> rdata[7:3] == 5'h00;
    endproperty
    a_rd_wday: assert property (p_rd_wday)
        else $error("weekday unused bits set");
    property p_rd_mday;
        ack && !$past(wr) && $past(addr) == 4'h4 |-> rdata[7:6] == 2'h0;
    endproperty
    a_rd_mday: assert property (p_rd_mday)
        else $error("date unused bits set");
    property p_rd_month;
        ack && !$past(wr) && $past(addr) == 4'h5 |-> rdata[7:5] == 3'h0;
    endproperty
    a_rd_month: assert property (p_rd_month)
        else $error("month unused bits set");
    property p_unmapped;
        ack && !$past(wr) && ($past(addr) == 4'h0 || $past(addr) > 4'h5)
            |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    c_read: cover property (ack && !wr);
    c_write: cover property (ack && wr);
    c_refused: cover property (refused);
endmodule
`default_nettype wire

//--- bcd_calendar_minutes_to_months_bench.sv
// Bench joining host and device ends through the shared interface.
// Assumes design files and bcdcal_cfg.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bcd_calendar_minutes_to_months_bench;
    import bcdcal_pkg::*;
    typedef struct {
        bcdcal_addr_t a;
        bcdcal_byte_t d;
        bcdcal_byte_t e;
    } bcdcal_row_t;
    logic clk_in = 0, rst_n_in = 0, tick = 0, carry = 0, ywrap = 0;
    logic leap = 0, osc = 0, osc_run = 1, pwr = 1, cv = 0, cw = 0;
    bcdcal_addr_t ca = 4'h0;
    bcdcal_byte_t cd = 8'h00, rdat, rd;
    logic ready, done, refd, flag, fvalid, rf;
    logic [2:0] oc = 3'h0;
    int failures = 0, check_count = 0, cyc = 0;
    bcdcal_row_t rows [9] = '{'{4'h1, 8'h45, 8'h45}, '{4'h2, 8'h23, 8'h23},
        '{4'h3, 8'hff, 8'h07}, '{4'h4, 8'hc5, 8'h05}, '{4'h4, 8'h31, 8'h31},
        '{4'h5, 8'he9, 8'h09}, '{4'h5, 8'h12, 8'h12}, '{4'h0, 8'h55, 8'h00},
        '{4'hf, 8'h5a, 8'h00}};
    bcdcal_if i_bcdcal_if();
    // Short gap and refresh counts keep the run brief
    bcdcal_dev #(.OSC_GAP_CYC(20), .REFRESH_CYC(100)) i_bcdcal_dev (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sec_tick_in(tick),
        .sec_carry_in(carry), .year_wrap_in(ywrap), .leap_year_in(leap),
        .osc_pulse_in(osc), .main_power_ok_in(pwr), .bus(i_bcdcal_if),
        .osc_fail_flag_out(flag), .fields_valid_out(fvalid));
    bcdcal_host i_bcdcal_host (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_addr_in(ca),
        .cmd_data_in(cd), .bus(i_bcdcal_if), .cmd_ready_out(ready),
        .done_out(done), .refused_out(refd), .rdata_out(rdat));
    bcdcal_asserts i_bcdcal_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .req(i_bcdcal_if.req), .wr(i_bcdcal_if.wr), .addr(i_bcdcal_if.addr),
        .wdata(i_bcdcal_if.wdata), .ack(i_bcdcal_if.ack),
        .refused(i_bcdcal_if.refused), .rdata(i_bcdcal_if.rdata));
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        oc <= oc + 3'h1;
        osc <= osc_run & oc[2];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input bcdcal_byte_t s, input bcdcal_byte_t e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    // One access; waits for the answer pulse, bounded
    task automatic acc(input logic w, input bcdcal_addr_t a,
                       input bcdcal_byte_t d);
        int n;
        n = 0;
        @(negedge clk_in);
        while (ready !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in);
        cv <= 1'b1;
        cw <= w;
        ca <= a;
        cd <= d;
        @(posedge clk_in);
        cv <= 1'b0;
        n = 0;
        @(negedge clk_in);
        while (done !== 1'b1 && refd !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        if (done !== 1'b1 && refd !== 1'b1) begin
            failures++;
            $display("BAD %0t no answer to access", $time);
        end
        rf = refd;
        rd = rdat;
    endtask
    task automatic rchk(input bcdcal_addr_t a, input bcdcal_byte_t e);
        acc(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    task automatic tick1(input logic lp);
        @(posedge clk_in);
        leap <= lp;
        @(posedge clk_in);
        tick <= 1'b1;
        carry <= 1'b1;
        @(posedge clk_in);
        tick <= 1'b0;
        carry <= 1'b0;
    endtask
    task automatic yw();
        @(posedge clk_in);
        ywrap <= 1'b1;
        @(posedge clk_in);
        ywrap <= 1'b0;
    endtask
    // Sets 23:59 on the given day, then one carried tick
    task automatic roll(input bcdcal_byte_t w, dd, m, input logic lp,
                        input bcdcal_byte_t ew, ed, em);
        acc(1'b1, 4'h1, 8'h59);
        acc(1'b1, 4'h2, 8'h23);
        acc(1'b1, 4'h3, w);
        acc(1'b1, 4'h4, dd);
        acc(1'b1, 4'h5, m);
        tick1(lp);
        rchk(4'h1, 8'h00);
        rchk(4'h2, 8'h00);
        rchk(4'h3, ew);
        rchk(4'h4, ed);
        rchk(4'h5, em);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk({7'h00, flag}, 8'h01);
        rchk(4'h1, 8'h80);
        $display("reset test done");
        foreach (rows[i]) begin
            acc(1'b1, rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e);
        end
        $display("register table test done");
        roll(8'h07, 8'h31, 8'h12, 1'b0, 8'h01, 8'h01, 8'h01);
        roll(8'h00, 8'h28, 8'h02, 1'b0, 8'h01, 8'h01, 8'h03);
        roll(8'h03, 8'h28, 8'h02, 1'b1, 8'h04, 8'h29, 8'h02);
        roll(8'h02, 8'h30, 8'h09, 1'b0, 8'h03, 8'h01, 8'h10);
        roll(8'h06, 8'h09, 8'h04, 1'b0, 8'h07, 8'h10, 8'h04);
        acc(1'b1, 4'h2, 8'h09);
        // Hours only step on a minute wrap
        acc(1'b1, 4'h1, 8'h59);
        tick1(1'b0);
        rchk(4'h2, 8'h10);
        acc(1'b1, 4'h1, 8'h69);
        tick1(1'b0);
        rchk(4'h1, 8'h70);
        acc(1'b1, 4'h1, 8'h0c);
        tick1(1'b0);
        rchk(4'h1, 8'h0d);
        $display("carry test done");
        acc(1'b1, 4'h2, 8'hc5);
        yw();
        rchk(4'h2, 8'h85);
        acc(1'b1, 4'h2, 8'h45);
        yw();
        rchk(4'h2, 8'h45);
        $display("century test done");
        @(posedge clk_in);
        pwr <= 1'b0;
        repeat (6) @(posedge clk_in);
        acc(1'b1, 4'h1, 8'h33);
        chk({7'h00, rf}, 8'h01);
        @(posedge clk_in);
        pwr <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk({7'h00, fvalid}, 8'h00);
        repeat (120) @(posedge clk_in);
        chk({7'h00, fvalid}, 8'h01);
        rchk(4'h1, 8'h0d);
        $display("supply test done");
        acc(1'b1, 4'h1, 8'h00);
        repeat (200) @(posedge clk_in);
        chk({7'h00, flag}, 8'h00);
        osc_run <= 1'b0;
        repeat (150) @(posedge clk_in);
        chk({7'h00, flag}, 8'h01);
        rchk(4'h1, 8'h80);
        $display("oscillator test done");
        end_of_test();
    end
endmodule
`default_nettype wire
